// *** rtl/lcd_drive_map.vh ***
// constants for the dot-matrix panel driver: register indices, fields,
// reset values, level codes and divider figures.
// assumes it is included by bare name from the driver's design files.
// How it works
// - 1/16 duty, 1/5 bias, 40 segments against 16 commons, 640 pixels.
// - driver fetches display memory itself each slot, no software per refresh.
// - eight segment pins each switchable between port and segment by one bit.
// - select bit 0 gives pin to port, 1 to segment; bit 0 is segment 39.
// - mode bit 7 turns display on; bit 6 picks low-voltage operation.
// - mode bit 4 zero cuts divider current; one supplies five drive levels.
// - clock bits 3:2 pick main/64, main/128, main/256 or subsystem clock.
// - clock bits 1:0 divide drive clock by 8 to 64; frame is that over 16.
// - reset clears mode register: display off, normal mode, divider cut.
// - reset clears segment-port select: all eight shared pins are ports.
// - reset clears clock select: main clock over 64, smallest division.
// - display memory sits at indices fa00 to fa4f; pixels come from it.
// - all 80 memory bytes are shown on the panel; none is spare read/write RAM.
// - memory bit 1 gives segment select level, 0 gives unselect level.
// - all levels swap between their two taps on alternate frames.
// - full on-voltage only when common and segment both at select level.
`ifndef LCD_DRIVE_MAP_VH
`define LCD_DRIVE_MAP_VH

`define MODE_IDX        16'hffb0
`define PORT_SEL_IDX    16'hffb1
`define CLK_SEL_IDX     16'hffb2
`define MEM_FIRST_IDX   16'hfa00
`define MEM_LAST_IDX    16'hfa4f
`define MEM_PAGE        9'h1f4
`define MEM_BYTES       80

`define MODE_RESET      8'h00
`define PORT_SEL_RESET  8'h00
`define CLK_SEL_RESET   8'h00
`define MODE_WMASK      8'hd0
`define CLK_WMASK       8'h0f

`define DISPLAY_ON_BIT  7
`define LOW_VOLT_BIT    6
`define DIV_POWER_BIT   4

`define SRC_MAIN_64     2'h0
`define SRC_MAIN_128    2'h1
`define SRC_MAIN_256    2'h2
`define SRC_SUB         2'h3

`define LVL_TOP         3'h0
`define LVL_1           3'h1
`define LVL_2           3'h2
`define LVL_3           3'h3
`define LVL_BOTTOM      3'h4
`define LVL_VSS         3'h5

`define SEGMENTS        40
`define COMMONS         16
`define SHARED_FIRST    32

`endif

// *** rtl/lcd_level_pick.v ***
// picks the drive level code of one segment or common line.
// assumes select and polarity come from flops of the same clock.
`timescale 1ns/1ps
`include "lcd_drive_map.vh"
module lcd_level_pick (
	input  wire       is_common,
	input  wire       sel,
	input  wire       polarity,
	output reg  [2:0] level
);
	// seg select vss/top, deselect 3/2; com select top/vss, deselect 4/1
	always @* begin
		level = `LVL_VSS;
		if (is_common) begin
			if (sel)
				level = polarity ? `LVL_VSS : `LVL_TOP;
			else
				level = polarity ? `LVL_1 : `LVL_BOTTOM;
		end else begin
			if (sel)
				level = polarity ? `LVL_TOP : `LVL_VSS;
			else
				level = polarity ? `LVL_2 : `LVL_3;
		end
	end
endmodule

// *** rtl/panel_driver_unit.v ***
// top of the dot-matrix panel driver: avalon-mm slave, display memory,
// drive clock dividers, common scan and registered line level codes.
// assumes SUB_CLK is an unrelated slow clock arriving on a pin.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "lcd_drive_map.vh"
module panel_driver_unit (
	input  wire         CORE_CLK,
	input  wire         NRST,
	input  wire         SUB_CLK,
	input  wire [17:0]  AVS_ADDRESS,
	input  wire         AVS_READ,
	input  wire         AVS_WRITE,
	input  wire [31:0]  AVS_WRITEDATA,
	input  wire [3:0]   AVS_BYTEENABLE,
	output reg  [31:0]  AVS_READDATA,
	output reg          AVS_WAITREQUEST,
	output reg  [119:0] SEG_LEVEL,
	output reg  [47:0]  COM_LEVEL,
	output reg  [39:0]  SEG_ENABLE,
	output reg          DIVIDER_ENABLE,
	output reg          LOW_VOLTAGE,
	output reg  [7:0]   SEGMENT_PORT_SELECT
);
	reg  [7:0]  display_mode_control;
	reg  [7:0]  segment_port_select;
	reg  [7:0]  drive_clock_select;
	reg  [7:0]  mem [0:`MEM_BYTES-1];
	reg  [7:0]  prescale;
	reg  [5:0]  drive_count;
	reg  [3:0]  slot;
	reg         polarity;
	reg  [39:0] seg_bits;
	reg         sub_meta;
	reg         sub_sync;
	reg         sub_last;
	wire [15:0] word_idx;
	wire        mem_hit;
	wire [6:0]  mem_idx;
	wire        access;
	wire        drive_clock;
	wire        slot_tick;
	wire [3:0]  next_slot;
	wire [39:0] next_bits;
	wire        display_on;
	wire [119:0] seg_code;
	wire [47:0]  com_code;
	reg  [7:0]  read_value;

	// all-ones test of the low bits of a counter, mask picked by a code
	function tick_of;
		input [7:0] count;
		input [1:0] code;
		input       coarse;
		reg   [7:0] mask;
		begin
			mask = 8'h00;
			if (coarse)
				mask = (code == `SRC_MAIN_64) ? 8'h3f :
				       (code == `SRC_MAIN_128) ? 8'h7f : 8'hff;
			else
				mask = (code == 2'h0) ? 8'h07 :
				       (code == 2'h1) ? 8'h0f :
				       (code == 2'h2) ? 8'h1f : 8'h3f;
			tick_of = ((count & mask) == mask);
		end
	endfunction

	assign word_idx = AVS_ADDRESS[17:2];
	// byte index is the low seven bits of the word index; the window starts
	// on a 128-word boundary, so no subtraction is needed
	assign mem_hit  = (word_idx >= `MEM_FIRST_IDX) &&
	                  (word_idx <= `MEM_LAST_IDX);
	assign mem_idx  = AVS_ADDRESS[8:2];
	assign access   = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	assign display_on = display_mode_control[`DISPLAY_ON_BIT];

	// read value is sampled at the edge that drops waitrequest
	always @* begin
		read_value = 8'h00;
		if (word_idx == `MODE_IDX)
			read_value = display_mode_control;
		else if (word_idx == `PORT_SEL_IDX)
			read_value = segment_port_select;
		else if (word_idx == `CLK_SEL_IDX)
			read_value = drive_clock_select;
		else if (mem_hit)
			read_value = mem[mem_idx];
	end

	// one wait cycle per access; unmapped reads give zero, writes vanish
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
		end else begin
			if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA    <= {24'h000000, read_value};
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
		end
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			display_mode_control <= `MODE_RESET;
			segment_port_select  <= `PORT_SEL_RESET;
			drive_clock_select   <= `CLK_SEL_RESET;
		end else if (access) begin
			// fixed-zero bits are not stored, so they always read zero
			if (word_idx == `MODE_IDX)
				display_mode_control <= AVS_WRITEDATA[7:0] & `MODE_WMASK;
			if (word_idx == `PORT_SEL_IDX)
				segment_port_select <= AVS_WRITEDATA[7:0];
			if (word_idx == `CLK_SEL_IDX)
				drive_clock_select <= AVS_WRITEDATA[7:0] & `CLK_WMASK;
		end
	end

	// memory is not reset; contents are undefined until software fills it
	always @(posedge CORE_CLK) begin
		if (access && mem_hit)
			mem[mem_idx] <= AVS_WRITEDATA[7:0];
	end

	// subsystem clock: two flops, then an edge detector on the second
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sub_meta <= 1'b0;
			sub_sync <= 1'b0;
			sub_last <= 1'b0;
		end else begin
			sub_meta <= SUB_CLK;
			sub_sync <= sub_meta;
			sub_last <= sub_sync;
		end
	end

	// drive clock is a one-cycle enable, never a real clock
	assign drive_clock = (drive_clock_select[3:2] == `SRC_SUB) ?
	                     (sub_sync && !sub_last) :
	                     tick_of(prescale, drive_clock_select[3:2], 1'b1);
	assign slot_tick = drive_clock &&
	                   tick_of({2'b00, drive_count},
	                           drive_clock_select[1:0], 1'b0);
	assign next_slot = slot + 4'h1;

	// fetch the forty bits of the coming slot straight from memory
	genvar s;
	generate
		for (s = 0; s < `SEGMENTS; s = s + 1) begin : fetch
			assign next_bits[s] =
				mem[2*s + next_slot[3]][next_slot[2:0]];
		end
	endgenerate

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			prescale    <= 8'h00;
			drive_count <= 6'h00;
			slot        <= 4'h0;
			polarity    <= 1'b0;
			seg_bits    <= 40'h0000000000;
		end else begin
			prescale <= prescale + 8'h01;
			if (drive_clock)
				drive_count <= drive_count + 6'h01;
			if (!display_on) begin
				slot     <= 4'h0;
				polarity <= 1'b0;
			end else if (slot_tick) begin
				slot     <= next_slot;
				seg_bits <= next_bits;
				if (slot == 4'hf)
					polarity <= !polarity;
			end
		end
	end

	generate
		for (s = 0; s < `SEGMENTS; s = s + 1) begin : seg_line
			lcd_level_pick u_pick (
				.is_common (1'b0),
				.sel       (seg_bits[s]),
				.polarity  (polarity),
				.level     (seg_code[3*s+2:3*s])
			);
		end
		for (s = 0; s < `COMMONS; s = s + 1) begin : com_line
			lcd_level_pick u_pick (
				.is_common (1'b1),
				.sel       (slot == s),
				.polarity  (polarity),
				.level     (com_code[3*s+2:3*s])
			);
		end
	endgenerate

	// lines rest at vss while the display is off or the divider is cut
	integer k;
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			SEG_LEVEL           <= {40{`LVL_VSS}};
			COM_LEVEL           <= {16{`LVL_VSS}};
			SEG_ENABLE          <= 40'h00ffffffff;
			DIVIDER_ENABLE      <= 1'b0;
			LOW_VOLTAGE         <= 1'b0;
			SEGMENT_PORT_SELECT <= 8'h00;
		end else begin
			DIVIDER_ENABLE <= display_mode_control[`DIV_POWER_BIT];
			LOW_VOLTAGE    <= display_mode_control[`LOW_VOLT_BIT];
			SEGMENT_PORT_SELECT <= segment_port_select;
			for (k = 0; k < `SEGMENTS; k = k + 1) begin
				if (k >= `SHARED_FIRST)
					SEG_ENABLE[k] <= segment_port_select[39-k];
				else
					SEG_ENABLE[k] <= 1'b1;
			end
			if (display_on && display_mode_control[`DIV_POWER_BIT]) begin
				SEG_LEVEL <= seg_code;
				COM_LEVEL <= com_code;
			end else begin
				SEG_LEVEL <= {40{`LVL_VSS}};
				COM_LEVEL <= {16{`LVL_VSS}};
			end
		end
	end
endmodule

// *** testbench/lcd_drive_asserts.sv ***
// checker of bus timing and register-driven outputs of the panel driver.
// assumes it is bound into panel_driver_unit and sees only its ports.
`timescale 1ns/1ps
module lcd_drive_asserts (
	input wire logic         CORE_CLK,
	input wire logic         NRST,
	input wire logic [17:0]  AVS_ADDRESS,
	input wire logic         AVS_READ,
	input wire logic         AVS_WRITE,
	input wire logic [31:0]  AVS_WRITEDATA,
	input wire logic [3:0]   AVS_BYTEENABLE,
	input wire logic [31:0]  AVS_READDATA,
	input wire logic         AVS_WAITREQUEST,
	input wire logic [119:0] SEG_LEVEL,
	input wire logic [47:0]  COM_LEVEL,
	input wire logic [39:0]  SEG_ENABLE,
	input wire logic         DIVIDER_ENABLE,
	input wire logic         LOW_VOLTAGE,
	input wire logic [7:0]   SEGMENT_PORT_SELECT
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	wire       req  = AVS_READ | AVS_WRITE;
	wire       wr   = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
	wire [15:0] idx = AVS_ADDRESS[17:2];
	a_answer_next: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("no answer one cycle after request");
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	a_no_spurious: assert property (!req && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer without request");
	a_read_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_off_vss: assert property (!DIVIDER_ENABLE && $past(!DIVIDER_ENABLE) |->
		COM_LEVEL == {16{3'h5}} && SEG_LEVEL == {40{3'h5}})
		else $error("lines driven while divider cut");
	a_seg_enable: assert property (SEG_ENABLE == {SEGMENT_PORT_SELECT[0],
		SEGMENT_PORT_SELECT[1], SEGMENT_PORT_SELECT[2], SEGMENT_PORT_SELECT[3],
		SEGMENT_PORT_SELECT[4], SEGMENT_PORT_SELECT[5], SEGMENT_PORT_SELECT[6],
		SEGMENT_PORT_SELECT[7], 32'hffffffff})
		else $error("segment enables do not follow port select");
	a_lowv_cause: assert property ($changed(LOW_VOLTAGE) |->
		$past(wr && idx == 16'hffb0, 2))
		else $error("low-voltage output changed without mode write");
	a_div_cause: assert property ($changed(DIVIDER_ENABLE) |->
		$past(wr && idx == 16'hffb0, 2))
		else $error("divider enable changed without mode write");
	a_port_cause: assert property ($changed(SEGMENT_PORT_SELECT) |->
		$past(wr && idx == 16'hffb1, 2)
		&& SEGMENT_PORT_SELECT == $past(AVS_WRITEDATA[7:0], 2))
		else $error("port select changed without matching write");
endmodule
bind panel_driver_unit lcd_drive_asserts u_lcd_drive_asserts (.CORE_CLK, .NRST,
	.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
	.AVS_READDATA, .AVS_WAITREQUEST, .SEG_LEVEL, .COM_LEVEL, .SEG_ENABLE,
	.DIVIDER_ENABLE, .LOW_VOLTAGE, .SEGMENT_PORT_SELECT);

// *** testbench/lcd_panel_model.sv ***
// passive panel: which pixels of one segment column see the on-voltage.
// assumes level codes 0 top tap and 5 vss are the two extremes.
`timescale 1ns/1ps
module lcd_panel_model #(parameter int SEG = 0) (
	input  wire logic [119:0] seg_level,
	input  wire logic [47:0]  com_level,
	output logic      [15:0]  lit
);
	// only opposite extremes give the full voltage, in either polarity
	always_comb begin
		for (int c = 0; c < 16; c++) begin
			lit[c] = (com_level[3*c+:3] == 3'h0 && seg_level[3*SEG+:3] == 3'h5)
				|| (com_level[3*c+:3] == 3'h5 && seg_level[3*SEG+:3] == 3'h0);
		end
	end
endmodule

// *** testbench/panel_driver_unit_tb.sv ***
// bench of the panel driver: register access over the slave bus and scan.
// assumes the design clock of 100 MHz and a free subsystem clock pin.
`timescale 1ns/1ps
module panel_driver_unit_tb;
	logic         CORE_CLK = 0;
	logic         NRST = 0;
	logic         SUB_CLK = 0;
	logic         AVS_READ = 0;
	logic         AVS_WRITE = 0;
	logic [17:0]  AVS_ADDRESS = 0;
	logic [31:0]  AVS_WRITEDATA = 0;
	logic [3:0]   AVS_BYTEENABLE = 4'hf;
	wire  [31:0]  AVS_READDATA;
	wire          AVS_WAITREQUEST;
	wire  [119:0] SEG_LEVEL;
	wire  [47:0]  COM_LEVEL;
	wire  [39:0]  SEG_ENABLE;
	wire          DIVIDER_ENABLE;
	wire          LOW_VOLTAGE;
	wire  [7:0]   SEGMENT_PORT_SELECT;
	wire  [15:0]  lit;
	logic [15:0]  seen;
	logic [7:0]   hit;
	logic [31:0]  rd;
	int           n_mismatch = 0;
	int           num_checks = 0;
	int           cyc = 0;
	int           n = 0;
	int           r = 0;
	int           sub_rises = 0;
	always #5 CORE_CLK = ~CORE_CLK;
	// half period chosen so subsystem edges never meet a rising core edge
	always #15260 SUB_CLK = ~SUB_CLK;
	always @(posedge SUB_CLK) sub_rises++;
	panel_driver_unit u_panel_driver_unit (.CORE_CLK, .NRST, .SUB_CLK,
		.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
		.AVS_READDATA, .AVS_WAITREQUEST, .SEG_LEVEL, .COM_LEVEL, .SEG_ENABLE,
		.DIVIDER_ENABLE, .LOW_VOLTAGE, .SEGMENT_PORT_SELECT);
	lcd_panel_model u_lcd_panel_model (.seg_level(SEG_LEVEL),
		.com_level(COM_LEVEL), .lit(lit));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a hang would stall the run forever, so cap it; the subsystem slots
	// alone take about fifty thousand cycles
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc > 90000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [119:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one slave access; entered just after a rising edge
	task automatic acc(input logic wr, input logic [15:0] idx,
		input logic [7:0] d);
		AVS_ADDRESS <= {idx, 2'b00};
		AVS_WRITEDATA <= {24'h0, d};
		AVS_READ <= !wr;
		AVS_WRITE <= wr;
		do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_READ <= 0;
		AVS_WRITE <= 0;
		@(posedge CORE_CLK);
	endtask
	// cycles and subsystem rises between two changes of the common levels;
	// the first change after a clock switch may close a short slot
	task automatic period(output int n_cyc, output int n_sub);
		logic [47:0] prev;
		int          r0;
		prev = COM_LEVEL;
		do @(posedge CORE_CLK); while (COM_LEVEL === prev);
		prev = COM_LEVEL;
		r0 = sub_rises;
		n_cyc = 0;
		do begin
			@(posedge CORE_CLK);
			n_cyc++;
		end while (COM_LEVEL === prev);
		n_sub = sub_rises - r0;
	endtask
	initial begin
		repeat (4) @(posedge CORE_CLK);
		NRST <= 1;
		@(posedge CORE_CLK);
		for (int i = 0; i < 3; i++) begin
			acc(0, 16'hffb0 + i, 0);
			chk("reg reset", rd, 0);
		end
		chk("seg enable reset", SEG_ENABLE, 40'h00ffffffff);
		$display("test reset done");
		// fixed-zero bits are written as zero and the display stays off
		acc(1, 16'hffb0, 8'h10);
		acc(0, 16'hffb0, 0);
		chk("mode", rd, 32'h10);
		chk("mode outs", {LOW_VOLTAGE, DIVIDER_ENABLE}, 2'h1);
		acc(1, 16'hffb2, 8'h0f);
		acc(0, 16'hffb2, 0);
		chk("clock select", rd, 32'h0f);
		acc(1, 16'hffb1, 8'h0f);
		acc(0, 16'hffb1, 0);
		chk("port select", rd, 32'h0f);
		chk("seg enable", SEG_ENABLE, 40'hf0ffffffff);
		// a write without the low byte lane must leave the register alone
		AVS_BYTEENABLE <= 4'he;
		acc(1, 16'hffb1, 8'h00);
		AVS_BYTEENABLE <= 4'hf;
		acc(0, 16'hffb1, 0);
		chk("lane disabled", rd, 32'h0f);
		acc(1, 16'hfa4f, 8'h5a);
		acc(1, 16'hfa50, 8'h77);
		acc(0, 16'hfa4f, 0);
		chk("memory last", rd, 32'h5a);
		acc(0, 16'hfa50, 0);
		chk("unmapped", rd, 0);
		$display("test registers done");
		// bring-up order: memory, pins, mode, then the drive clock
		acc(1, 16'hffb0, 8'h00);
		acc(1, 16'hfa00, 8'h01);
		acc(1, 16'hfa01, 8'h80);
		acc(1, 16'hffb1, 8'h0f);
		acc(1, 16'hffb0, 8'hd0);
		acc(1, 16'hffb2, 8'h00);
		period(n, r);
		chk("slot period 64/8", n, 512);
		seen = 0;
		hit = 0;
		// two frames of 16 slots, 512 cycles each, covers both polarities
		repeat (16600) begin
			@(posedge CORE_CLK);
			seen = seen | lit;
			hit[COM_LEVEL[2:0]] = 1'b1;
		end
		chk("lit pixels", seen, 16'h8001);
		chk("common 0 levels", hit, 8'h33);
		chk("low voltage on", LOW_VOLTAGE, 1'b1);
		acc(1, 16'hffb2, 8'h06);
		period(n, r);
		chk("slot period 128/32", n, 4096);
		// subsystem slots are 24416 cycles here, but count its rises to check the division by 8
		acc(1, 16'hffb2, 8'h0c);
		period(n, r);
		chk("sub rises per slot", r, 8);
		$display("test scan done");
		// display off first, only then may the low-voltage bit change
		acc(1, 16'hffb0, 8'h50);
		repeat (3) @(posedge CORE_CLK);
		chk("off seg levels", SEG_LEVEL, {40{3'h5}});
		chk("off com levels", COM_LEVEL, {16{3'h5}});
		acc(1, 16'hffb0, 8'h00);
		repeat (3) @(posedge CORE_CLK);
		chk("power off", {LOW_VOLTAGE, DIVIDER_ENABLE}, 2'h0);
		// a second reset in mid-run must clear the three registers written so far
		NRST <= 0;
		repeat (2) @(posedge CORE_CLK);
		NRST <= 1;
		@(posedge CORE_CLK);
		for (int i = 0; i < 3; i++) begin
			acc(0, 16'hffb0 + i, 0);
			chk("reg mid reset", rd, 0);
		end
		chk("seg enable mid reset", SEG_ENABLE, 40'h00ffffffff);
		$display("test mid reset done");
		end_sim();
	end
endmodule
